/* rtl/cssc_top.sv */
// Clock source selection and start-up control.
// Assumes oscillator outputs arrive as asynchronous levels and the
// analog mux and amplifier follow the select and gain outputs.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "cssc_cfg.svh"
module cssc_top #(
	parameter int TRIM_W = 5,
	parameter int WARM_EDGES = `CSSC_WARM_EDGES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Configuration word
	input wire logic [2:0] clock_mode_config,
	input wire logic two_speed_startup_enable,
	// Core events
	input wire logic powerup_delay_done,
	input wire logic sleep_req,
	input wire logic wake_req,
	output logic cpu_hold,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Oscillator signals
	input wire logic crystal_in_pin,
	input wire logic fast_osc_in,
	input wire logic slow_osc_in,
	output logic fast_osc_enable,
	output logic [TRIM_W-1:0] fast_osc_trim_out,
	output logic [1:0] amp_gain,
	output logic sys_clk_internal,
	output logic sys_tick,
	// Pin control
	output logic divided_clock_output,
	output logic divided_clock_output_oe,
	output logic crystal_out_gpio_release,
	output logic clock_input_gpio_release
);
	function automatic cssc_pkg::cssc_mode_t decode_mode(input logic [2:0] code);
		case (code)
			`CSSC_CFG_LOW_XTAL: decode_mode = cssc_pkg::MODE_LOW_XTAL;
			`CSSC_CFG_MID_XTAL: decode_mode = cssc_pkg::MODE_MID_XTAL;
			`CSSC_CFG_HIGH_XTAL: decode_mode = cssc_pkg::MODE_HIGH_XTAL;
			`CSSC_CFG_DRIVEN: decode_mode = cssc_pkg::MODE_DRIVEN;
			`CSSC_CFG_INT_IO: decode_mode = cssc_pkg::MODE_INT_IO;
			`CSSC_CFG_INT_DIV: decode_mode = cssc_pkg::MODE_INT_DIV;
			`CSSC_CFG_RC_IO: decode_mode = cssc_pkg::MODE_RC_IO;
			default: decode_mode = cssc_pkg::MODE_RC_DIV;
		endcase
	endfunction : decode_mode

	function automatic logic is_internal(input cssc_pkg::cssc_mode_t m);
		is_internal = (m == cssc_pkg::MODE_INT_IO) || (m == cssc_pkg::MODE_INT_DIV);
	endfunction : is_internal

	// Three-stage synchronisers for the oscillator levels
	localparam int NSYNC = 3;
	wire logic [NSYNC-1:0] raw_in = {slow_osc_in, fast_osc_in, crystal_in_pin};
	logic [NSYNC-1:0] sync1_ff, sync2_ff, sync3_ff, lvl_ff;
	logic [NSYNC-1:0] rise;

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// A change counts only once the last two stages agree
			wire logic agree = (sync2_ff[gi] == sync3_ff[gi]);
			assign rise[gi] = agree && sync3_ff[gi] && !lvl_ff[gi];
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					sync1_ff[gi] <= 1'b0;
					sync2_ff[gi] <= 1'b0;
					sync3_ff[gi] <= 1'b0;
					lvl_ff[gi] <= 1'b0;
				end else begin
					sync1_ff[gi] <= raw_in[gi];
					sync2_ff[gi] <= sync1_ff[gi];
					sync3_ff[gi] <= sync2_ff[gi];
					lvl_ff[gi] <= agree ? sync3_ff[gi] : lvl_ff[gi];
				end
			end
		end
	endgenerate

	wire logic ext_edge = rise[0];
	wire logic fast_edge = rise[1] && fast_osc_enable;
	wire logic slow_edge = rise[2];

	// Registers
	logic [2:0] fsel_ff;
	logic src_sel_ff;
	logic [TRIM_W-1:0] trim_ff;
	logic [7:0] rdata_ff;
	cssc_pkg::cssc_state_t state_ff, nxt_state;
	cssc_pkg::cssc_src_t active_src_ff, nxt_active;
	logic [10:0] xtal_cnt_ff, nxt_xtal_cnt;
	logic [7:0] fast_warm_ff, slow_warm_ff;
	logic [1:0] sw_cnt_ff, nxt_sw_cnt;

	// Mode and source decode
	wire cssc_pkg::cssc_mode_t mode = decode_mode(clock_mode_config);
	wire logic mode_xtal = (mode == cssc_pkg::MODE_LOW_XTAL) ||
		(mode == cssc_pkg::MODE_MID_XTAL) || (mode == cssc_pkg::MODE_HIGH_XTAL);
	wire logic mode_int = is_internal(mode);
	wire cssc_pkg::cssc_src_t desired_src =
		(src_sel_ff || mode_int) ? cssc_pkg::SRC_INT : cssc_pkg::SRC_EXT;

	// Fast oscillator enable and stability
	assign fast_osc_enable = (fsel_ff != 3'h0) && (src_sel_ff || two_speed_startup_enable);
	wire logic fast_ok = (fast_warm_ff == 8'(WARM_EDGES));
	wire logic slow_ok = (slow_warm_ff == 8'(WARM_EDGES));

	// Postscaler: select 7 passes 8 MHz, each step down to select 1 halves it; select 0 uses the slow oscillator
	wire logic [2:0] post_log = `CSSC_FSEL_TOP - fsel_ff;
	logic post_pulse;
	cssc_pulse_div #(.CW(7)) u_post (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pulse_in(fast_edge),
		.div_log(post_log),
		.pulse_out(post_pulse),
		.sq_out()
	);

	wire logic int_tick = (fsel_ff == 3'h0) ? slow_edge : post_pulse;
	wire logic int_ready = (fsel_ff == 3'h0) ? slow_ok : fast_ok;
	wire logic new_src_edge = (desired_src == cssc_pkg::SRC_INT) ? int_tick : ext_edge;
	assign sys_tick = (active_src_ff == cssc_pkg::SRC_INT) ? int_tick : ext_edge;
	assign sys_clk_internal = (active_src_ff == cssc_pkg::SRC_INT);

	// Clock output divider
	wire logic divout_mode = (mode == cssc_pkg::MODE_RC_DIV) || (mode == cssc_pkg::MODE_INT_DIV);
	wire logic div_src = mode_int ? int_tick : ext_edge;
	logic div_sq;
	cssc_pulse_div #(.CW(3)) u_divided_clock_output (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.pulse_in(div_src),
		.div_log(`CSSC_DIVIDED_CLOCK_OUTPUT_LOG),
		.pulse_out(),
		.sq_out(div_sq)
	);

	assign divided_clock_output = divout_mode && div_sq;
	assign divided_clock_output_oe = divout_mode;
	assign crystal_out_gpio_release = (mode == cssc_pkg::MODE_DRIVEN) ||
		(mode == cssc_pkg::MODE_RC_IO) || (mode == cssc_pkg::MODE_INT_IO);
	assign clock_input_gpio_release = mode_int;

	// Amplifier gain follows the crystal mode; off otherwise
	assign amp_gain = (mode == cssc_pkg::MODE_LOW_XTAL) ? cssc_pkg::GAIN_LOW :
		(mode == cssc_pkg::MODE_MID_XTAL) ? cssc_pkg::GAIN_MID :
		(mode == cssc_pkg::MODE_HIGH_XTAL) ? cssc_pkg::GAIN_HIGH :
		cssc_pkg::GAIN_OFF;

	assign fast_osc_trim_out = trim_ff;
	assign cpu_hold = (state_ff != cssc_pkg::ST_RUN) && (state_ff != cssc_pkg::ST_SWITCH);

	// Start-up and switching sequencer
	always_comb begin
		nxt_state = state_ff;
		nxt_active = active_src_ff;
		nxt_xtal_cnt = xtal_cnt_ff;
		nxt_sw_cnt = sw_cnt_ff;
		case (state_ff)
			cssc_pkg::ST_START: begin
				nxt_xtal_cnt = '0;
				nxt_active = desired_src;
				if (powerup_delay_done) begin
					if (desired_src == cssc_pkg::SRC_INT)
						nxt_state = cssc_pkg::ST_WARM;
					else if (mode_xtal)
						nxt_state = cssc_pkg::ST_XTAL_COUNT;
					else
						nxt_state = cssc_pkg::ST_RUN;
				end
			end
			cssc_pkg::ST_XTAL_COUNT: begin
				if (ext_edge) begin
					nxt_xtal_cnt = xtal_cnt_ff + 11'h001;
					if (xtal_cnt_ff == 11'(`CSSC_XTAL_START_EDGES - 1))
						nxt_state = cssc_pkg::ST_RUN;
				end
			end
			cssc_pkg::ST_WARM: begin
				if (int_ready)
					nxt_state = cssc_pkg::ST_RUN;
			end
			cssc_pkg::ST_RUN: begin
				nxt_sw_cnt = '0;
				if (sleep_req)
					nxt_state = cssc_pkg::ST_SLEEP;
				else if (desired_src != active_src_ff)
					nxt_state = cssc_pkg::ST_SWITCH;
			end
			cssc_pkg::ST_SWITCH: begin
				// Old clock keeps running the core until the new one settles
				if (desired_src == active_src_ff) begin
					nxt_state = cssc_pkg::ST_RUN;
				end else if (new_src_edge && (desired_src == cssc_pkg::SRC_EXT || int_ready)) begin
					nxt_sw_cnt = sw_cnt_ff + 2'h1;
					if (sw_cnt_ff == 2'(`CSSC_SWITCH_EDGES - 1)) begin
						nxt_active = desired_src;
						nxt_state = cssc_pkg::ST_RUN;
					end
				end
			end
			cssc_pkg::ST_SLEEP: begin
				if (wake_req)
					nxt_state = cssc_pkg::ST_START;
			end
			default: nxt_state = cssc_pkg::ST_START;
		endcase
	end

	// All state moves only on clk_sys; a stopped clock freezes it
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= cssc_pkg::ST_START;
			active_src_ff <= cssc_pkg::SRC_EXT;
			xtal_cnt_ff <= '0;
			sw_cnt_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			active_src_ff <= nxt_active;
			xtal_cnt_ff <= nxt_xtal_cnt;
			sw_cnt_ff <= nxt_sw_cnt;
		end
	end

	// Warm-up counters saturate; the fast one restarts when disabled
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fast_warm_ff <= '0;
			slow_warm_ff <= '0;
		end else begin
			if (!fast_osc_enable)
				fast_warm_ff <= '0;
			else if (fast_edge && !fast_ok)
				fast_warm_ff <= fast_warm_ff + 8'h01;
			if (slow_edge && !slow_ok)
				slow_warm_ff <= slow_warm_ff + 8'h01;
		end
	end

	// Register port
	wire logic sel_ctrl = (reg_addr == `CSSC_REG_CTRL);
	wire logic sel_trim = (reg_addr == `CSSC_REG_TRIM);
	wire logic [7:0] ctrl_view = {1'b0, fsel_ff,
		active_src_ff == cssc_pkg::SRC_EXT, fast_ok, slow_ok, src_sel_ff};
	wire logic [7:0] rd_mux = sel_ctrl ? ctrl_view :
		sel_trim ? 8'(trim_ff) : 8'h00;
	assign reg_rdata = rdata_ff;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fsel_ff <= `CSSC_FSEL_RST;
			src_sel_ff <= `CSSC_SRC_RST;
			trim_ff <= TRIM_W'(`CSSC_TRIM_RST);
			rdata_ff <= 8'h00;
		end else begin
			if (reg_wr && sel_ctrl) begin
				fsel_ff <= reg_wdata[`CSSC_CTRL_FSEL_MSB:`CSSC_CTRL_FSEL_LSB];
				src_sel_ff <= reg_wdata[`CSSC_CTRL_SRC_BIT];
			end
			if (reg_wr && sel_trim)
				trim_ff <= reg_wdata[TRIM_W-1:0];
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Checks
	sequence s_count_last;
		state_ff == cssc_pkg::ST_XTAL_COUNT && ext_edge &&
			xtal_cnt_ff == 11'(`CSSC_XTAL_START_EDGES - 1);
	endsequence
	sequence s_switch_req;
		state_ff == cssc_pkg::ST_RUN && !sleep_req && desired_src != active_src_ff;
	endsequence

	property p_xtal_done;
		@(posedge clk_sys) disable iff (!reset_n)
		s_count_last |=> state_ff == cssc_pkg::ST_RUN && !cpu_hold;
	endproperty
	a_xtal_done: assert property (p_xtal_done) else $error("start-up count end missed");

	property p_hold_count;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == cssc_pkg::ST_XTAL_COUNT &&
			!(ext_edge && xtal_cnt_ff == 11'(`CSSC_XTAL_START_EDGES - 1))) |=>
			state_ff == cssc_pkg::ST_XTAL_COUNT && cpu_hold;
	endproperty
	a_hold_count: assert property (p_hold_count) else $error("core ran during start-up");

	property p_switch;
		@(posedge clk_sys) disable iff (!reset_n)
		s_switch_req |=> state_ff == cssc_pkg::ST_SWITCH ##0 $stable(active_src_ff);
	endproperty
	a_switch: assert property (p_switch) else $error("source switched without delay");

	property p_warm;
		@(posedge clk_sys) disable iff (!reset_n)
		($past(state_ff) == cssc_pkg::ST_WARM && state_ff == cssc_pkg::ST_RUN) |-> $past(int_ready);
	endproperty
	a_warm: assert property (p_warm) else $error("internal clock used before warm-up");

	property p_driven_no_count;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_ff == cssc_pkg::ST_START && powerup_delay_done && !mode_xtal &&
			desired_src == cssc_pkg::SRC_EXT) |=> state_ff == cssc_pkg::ST_RUN;
	endproperty
	a_driven_no_count: assert property (p_driven_no_count) else $error("count in driven mode");

	property p_gain;
		@(posedge clk_sys) disable iff (!reset_n)
		mode == cssc_pkg::MODE_MID_XTAL |-> amp_gain == 2'h2;
	endproperty
	a_gain: assert property (p_gain) else $error("wrong amplifier gain");

	// Divided output may only move on a source edge
	sequence s_rc_quiet;
		mode == cssc_pkg::MODE_RC_DIV && !ext_edge ##1 mode == cssc_pkg::MODE_RC_DIV;
	endsequence
	property p_divout;
		@(posedge clk_sys) disable iff (!reset_n)
		s_rc_quiet |-> divided_clock_output_oe && !crystal_out_gpio_release &&
			$stable(divided_clock_output);
	endproperty
	a_divout: assert property (p_divout) else $error("clock output pin not driven");

	property p_both_free;
		@(posedge clk_sys) disable iff (!reset_n)
		mode == cssc_pkg::MODE_INT_IO |->
			crystal_out_gpio_release && clock_input_gpio_release && !divided_clock_output_oe;
	endproperty
	a_both_free: assert property (p_both_free) else $error("pins not released");

	property p_fast_en;
		@(posedge clk_sys) disable iff (!reset_n)
		fsel_ff == 3'h0 |-> !fast_osc_enable ##1 fast_warm_ff == 8'h00 && !fast_ok;
	endproperty
	a_fast_en: assert property (p_fast_en) else $error("fast oscillator enabled at select 0");

	property p_ext_flag;
		@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && sel_ctrl) |=> reg_rdata[`CSSC_CTRL_EXT_BIT] == !$past(sys_clk_internal);
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag wrong");
endmodule : cssc_top

/* rtl/cssc_cfg.svh */
// Constants for the clock source and start-up control block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef CSSC_CFG_SVH
`define CSSC_CFG_SVH

// Register indices on the plain register port
`define CSSC_REG_CTRL 4'h0
`define CSSC_REG_TRIM 4'h1

// Control register field positions
`define CSSC_CTRL_SRC_BIT 0
`define CSSC_CTRL_SLOW_OK_BIT 1
`define CSSC_CTRL_FAST_OK_BIT 2
`define CSSC_CTRL_EXT_BIT 3
`define CSSC_CTRL_FSEL_LSB 4
`define CSSC_CTRL_FSEL_MSB 6

// Reset values
`define CSSC_FSEL_RST 3'h6
`define CSSC_SRC_RST 1'h0
`define CSSC_TRIM_RST 5'h00

// Clock mode configuration codes
`define CSSC_CFG_LOW_XTAL 3'h0
`define CSSC_CFG_MID_XTAL 3'h1
`define CSSC_CFG_HIGH_XTAL 3'h2
`define CSSC_CFG_DRIVEN 3'h3
`define CSSC_CFG_INT_IO 3'h4
`define CSSC_CFG_INT_DIV 3'h5
`define CSSC_CFG_RC_IO 3'h6
`define CSSC_CFG_RC_DIV 3'h7

// Timing counts in oscillator edges; output divider log2 and postscaler top select
`define CSSC_XTAL_START_EDGES 1024
`define CSSC_WARM_EDGES 16
`define CSSC_SWITCH_EDGES 2
`define CSSC_DIVIDED_CLOCK_OUTPUT_LOG 3'h2
`define CSSC_FSEL_TOP 3'h7

`endif

/* rtl/cssc_pkg.sv */
// Types shared by the clock source and start-up control block.
// Assumes nothing of its surroundings.
package cssc_pkg;
	typedef enum logic [2:0] {
		MODE_LOW_XTAL, MODE_MID_XTAL, MODE_HIGH_XTAL, MODE_DRIVEN,
		MODE_INT_IO, MODE_INT_DIV, MODE_RC_IO, MODE_RC_DIV
	} cssc_mode_t;
	typedef enum logic [2:0] {
		ST_START, ST_XTAL_COUNT, ST_WARM, ST_RUN, ST_SWITCH, ST_SLEEP
	} cssc_state_t;
	typedef enum logic {SRC_EXT, SRC_INT} cssc_src_t;
	typedef enum logic [1:0] {GAIN_OFF, GAIN_LOW, GAIN_MID, GAIN_HIGH} cssc_gain_t;
endpackage : cssc_pkg

/* rtl/cssc_pulse_div.sv */
// Power-of-two pulse divider: postscaler and clock output divider.
// Assumes pulse_in is a one-cycle pulse on clk_sys.
`timescale 1ns/1ns
module cssc_pulse_div #(
	parameter int CW = 7
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Pulses
	input wire logic pulse_in,
	input wire logic [2:0] div_log,
	output logic pulse_out,
	output logic sq_out
);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	wire logic [CW-1:0] mask = CW'((32'h1 << div_log) - 32'h1);

	assign nxt_cnt = pulse_in ? cnt_ff + 1'b1 : cnt_ff;
	assign pulse_out = pulse_in && ((cnt_ff & mask) == mask);
	// Square wave toggles every half period of the divided rate
	assign sq_out = (div_log == 3'h0) ? 1'b0 : 1'(cnt_ff >> (div_log - 3'h1));

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : cssc_pulse_div

/* sim/cssc_osc_model.sv */
// Behavioural oscillators on the far side of the clock control block.
// Assumes the bench gates the crystal and the block gates the fast one.
`timescale 1ns/1ns
module cssc_osc_model #(
	parameter int XTAL_HALF_NS = 200,
	parameter int FAST_HALF_NS = 120,
	parameter int SLOW_HALF_NS = 400
) (
	// Gates
	input wire logic crystal_run,
	input wire logic fast_osc_enable,
	// Oscillator levels
	output logic crystal_in_pin,
	output logic fast_osc_in,
	output logic slow_osc_in
);
	initial begin
		crystal_in_pin = 1'h0;
		fast_osc_in = 1'h0;
		slow_osc_in = 1'h0;
	end
	// Stopped source freezes at its level, like a halted external clock
	always #(XTAL_HALF_NS) if (crystal_run) crystal_in_pin = ~crystal_in_pin;
	// Disabled fast source stands low, never a stale toggle
	always #(FAST_HALF_NS) fast_osc_in = fast_osc_enable ? ~fast_osc_in : 1'h0;
	always #(SLOW_HALF_NS) slow_osc_in = ~slow_osc_in;
endmodule : cssc_osc_model

/* sim/tb_top.sv */
// Self-checking bench for the clock source and start-up control block.
// Assumes the oscillator model drives all oscillator inputs.
`timescale 1ns/1ns
`include "cssc_cfg.svh"
module tb_top;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic [2:0] mode = 3'h1;
	logic two_speed = 1'h0;
	logic sleep_req = 1'h0;
	logic wake_req = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic xrun = 1'h1;
	logic pwr_done = 1'h1;
	logic cpu_hold, fast_en, sys_int, sys_tick, div_out, div_oe, out_rel, in_rel, xin, fin, sin;
	logic [7:0] reg_rdata;
	logic [4:0] trim;
	logic [1:0] gain;
	int mismatches = 0;
	int checks = 0;

	always #20 clk_sys = ~clk_sys;

	// Short warm-up keeps internal start-up quick
	cssc_top #(.TRIM_W(5), .WARM_EDGES(2)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .clock_mode_config(mode),
		.two_speed_startup_enable(two_speed), .powerup_delay_done(pwr_done),
		.sleep_req(sleep_req), .wake_req(wake_req), .cpu_hold(cpu_hold),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .crystal_in_pin(xin), .fast_osc_in(fin), .slow_osc_in(sin),
		.fast_osc_enable(fast_en), .fast_osc_trim_out(trim), .amp_gain(gain),
		.sys_clk_internal(sys_int), .sys_tick(sys_tick), .divided_clock_output(div_out),
		.divided_clock_output_oe(div_oe), .crystal_out_gpio_release(out_rel),
		.clock_input_gpio_release(in_rel)
	);
	cssc_osc_model osc (
		.crystal_run(xrun), .fast_osc_enable(fast_en),
		.crystal_in_pin(xin), .fast_osc_in(fin), .slow_osc_in(sin)
	);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// Release just after a crystal fall, so every later rise is counted
	task automatic do_reset(input logic [2:0] m, input logic ts);
		@(posedge clk_sys);
		reset_n <= 1'h0;
		mode <= m;
		two_speed <= ts;
		pwr_done <= (m != 3'h3);
		cyc(16);
		@(negedge xin);
		@(posedge clk_sys);
		reset_n <= 1'h1;
	endtask : do_reset

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic count_ticks(input int n, output int t);
		t = 0;
		repeat (n) begin
			@(posedge clk_sys);
			if (sys_tick === 1'h1) t++;
		end
	endtask : count_ticks

	task automatic count_div(output int t, output int r);
		logic last;
		t = 0;
		r = 0;
		last = div_out;
		repeat (480) begin
			@(posedge clk_sys);
			if (sys_tick === 1'h1) t++;
			if (div_out === 1'h1 && last === 1'h0) r++;
			last = div_out;
		end
	endtask : count_div

	// Margins cover the three-flop input synchroniser
	task automatic xtal_count;
		repeat (1023) @(posedge xin);
		cyc(7);
		chk("hold_before_count", cpu_hold, 1'h1);
		@(posedge xin);
		cyc(9);
		chk("hold_after_count", cpu_hold, 1'h0);
	endtask : xtal_count

	task automatic t_startup;
		logic [7:0] d;
		#1;
		chk("hold_at_release", cpu_hold, 1'h1);
		xtal_count();
		rd(`CSSC_REG_CTRL, d);
		chk("ctrl_reset", d & 8'hF1, 8'h60);
		rd(4'hF, d);
		chk("unmapped_read", d, 8'h00);
	endtask : t_startup

	task automatic t_static;
		int t;
		@(posedge clk_sys);
		xrun <= 1'h0;
		cyc(10);
		count_ticks(200, t);
		chk("ticks_stopped", t, 0);
		chk("hold_stopped", cpu_hold, 1'h0);
		xrun <= 1'h1;
		count_ticks(200, t);
		chk("ticks_resumed", t >= 18 && t <= 21, 1'h1);
	endtask : t_static

	task automatic t_sleep_wake;
		@(posedge clk_sys);
		sleep_req <= 1'h1;
		@(posedge clk_sys);
		sleep_req <= 1'h0;
		cyc(3);
		chk("hold_in_sleep", cpu_hold, 1'h1);
		@(negedge xin);
		@(posedge clk_sys);
		wake_req <= 1'h1;
		@(posedge clk_sys);
		wake_req <= 1'h0;
		xtal_count();
	endtask : t_sleep_wake

	task automatic t_switch;
		logic [7:0] d;
		int t;
		int exp_t[3] = '{100, 50, 25};
		wr(`CSSC_REG_TRIM, 8'h15);
		#1;
		chk("trim_out", trim, 5'h15);
		wr(4'h9, 8'hFF);
		rd(`CSSC_REG_TRIM, d);
		chk("trim_read", d, 8'h15);
		wr(`CSSC_REG_CTRL, 8'h71);
		#1;
		chk("fast_enable", fast_en, 1'h1);
		chk("no_instant_switch", sys_int, 1'h0);
		for (int i = 0; i < 300 && sys_int !== 1'h1; i++) @(posedge clk_sys);
		chk("internal_active", sys_int, 1'h1);
		chk("hold_on_switch", cpu_hold, 1'h0);
		rd(`CSSC_REG_CTRL, d);
		chk("flags_internal", d & 8'h0C, 8'h04);
		for (int i = 0; i < 3; i++) begin
			wr(`CSSC_REG_CTRL, {1'h0, 3'(7 - i), 4'h1});
			cyc(30);
			count_ticks(600, t);
			chk("tick_rate", t >= exp_t[i] - 2 && t <= exp_t[i] + 2, 1'h1);
		end
		wr(`CSSC_REG_CTRL, 8'h01);
		#1;
		chk("fast_off", fast_en, 1'h0);
		cyc(100);
		count_ticks(600, t);
		chk("slow_rate", t >= 28 && t <= 32, 1'h1);
		// Status bits set in the write must not stick
		wr(`CSSC_REG_CTRL, 8'h6E);
		for (int i = 0; i < 300 && sys_int !== 1'h0; i++) @(posedge clk_sys);
		chk("external_active", sys_int, 1'h0);
		rd(`CSSC_REG_CTRL, d);
		chk("flags_external", d & 8'h0F, 8'h0A);
	endtask : t_switch

	task automatic t_modes;
		int t;
		int r;
		for (int m = 0; m < 8; m++) begin
			do_reset(3'(m), 1'h1);
			#1;
			chk("gain", gain, m < 3 ? m + 1 : 0);
			chk("divided_clock_output_oe", div_oe, m == 5 || m == 7);
			chk("out_pin_free", out_rel, m == 3 || m == 4 || m == 6);
			chk("in_pin_free", in_rel, m == 4 || m == 5);
			if (m >= 3) begin
				if (m == 3) begin
					cyc(20);
					chk("powerup_wait", cpu_hold, 1'h1);
					pwr_done <= 1'h1;
				end
				if (m == 4 || m == 5) chk("warm_hold", cpu_hold, 1'h1);
				for (int i = 0; i < (m == 4 || m == 5 ? 400 : 3) && cpu_hold !== 1'h0; i++)
					@(posedge clk_sys);
				chk("run_hold", cpu_hold, 1'h0);
			end
			if (m == 5 || m == 7) begin
				count_div(t, r);
				chk("div_by_four", r > 0 && r * 4 >= t - 4 && r * 4 <= t + 4, 1'h1);
			end
		end
	endtask : t_modes

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done

	initial begin
		do_reset(3'h1, 1'h0);
		t_startup();
		t_static();
		t_sleep_wake();
		t_switch();
		t_modes();
		test_done();
	end

	// About three times the expected run
	initial begin
		#3000000;
		mismatches++;
		test_done();
	end
endmodule : tb_top
